// *** design/cms_core_mode_status.v ***
// Behaviour
// R1: Cache enable bit set turns on the cache controller, fetching from program RAM.
// R2: Cache enable bit clear disables cache; fetch follows memory map.
// R3: Software must not clear cache enable while burst enable is set.
// R4: Software writes zero to reserved bit 18.
// R5: Sixteen-bit bit set selects 16-bit arithmetic instead of 24-bit.
// R6: Sixteen-bit data is right-aligned in 24-bit locations and registers.
// R7: Endless-loop flag bit 16 sets when an endless loop starts.
// R8: Endless-loop flag stacked on entry and restored on loop termination.
// R9: Return from long interrupt pulls stack and restores endless-loop flag.
// R10: Loop-active flag bit 15 enables loop end detection while looping.
// R11: Loop-active flag stacked on loop entry, restored on termination.
// R12: Return from long interrupt pulls stack and restores loop-active flag.
// R13: Double-precision bit 14 set makes four MAC ops form 48x48 multiply.
// R14: Clearing double-precision bit returns the four ops to normal.
// R15: Software uses the four ops in that mode only for the algorithm.
// R16: Software keeps second input low register unchanged during that algorithm.
// R17: Rounding bit 21 clear selects convergent, set selects two's-complement.
// R18: Saturation bit set saturates 48-bit MAC results at the 48-bit limit.
// R19: Status bits 14 to 21, reserved included, reset to zero.
`timescale 1ns/1ps
`include "cms_defs.vh"
module cms_core_mode_status (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Core sequencer events, same clock
    input wire loop_start,
    input wire endless_loop_start,
    input wire loop_end,
    input wire int_entry,
    input wire return_from_interrupt,
    input wire loop_end_hit,
    input wire burst_enable,
    // Mode, flag, loop-end detect and stack error outputs
    output reg cache_enable,
    output reg rounding_mode_select,
    output reg arith_saturation_mode,
    output reg sixteen_bit_arith_mode,
    output reg endless_loop_flag,
    output reg loop_active_flag,
    output reg double_precision_mode,
    output reg loop_end_detect,
    output reg stack_error
);
    reg [23:0] status_r;
    reg [23:0] status_nxt;
    reg [1:0] stack_mem [0:`CMS_STACK_DEPTH-1];
    reg [`CMS_STACK_PTR_W-1:0] sp_r;
    reg [`CMS_STACK_PTR_W-1:0] sp_nxt;
    reg ovf_r;
    reg [31:0] rd_nxt;
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i;
    wire st_wr = wb_wr & (wb_adr_i == `CMS_ADDR_STATUS);
    wire clr_wr = wb_wr & (wb_adr_i == `CMS_ADDR_LOOPCTL) & wb_sel_i[0] & wb_dat_i[0];
    wire push = loop_start | endless_loop_start | int_entry;
    wire pop = loop_end | return_from_interrupt;
    wire empty = (sp_r == {`CMS_STACK_PTR_W{1'b0}});
    wire full = (sp_r == 5'h10);
    wire [1:0] top = stack_mem[sp_r[3:0] - 4'h1];
    wire [23:0] wdat = {wb_sel_i[2] ? wb_dat_i[23:16] : status_r[23:16],
        wb_sel_i[1] ? wb_dat_i[15:8] : status_r[15:8], status_r[7:0]};

    always @* begin
        status_nxt = status_r;
        sp_nxt = sp_r;
        if (st_wr) begin
            // Reserved bit forced to zero [R4]
            status_nxt = (status_r & ~`CMS_WR_MASK) | (wdat & `CMS_WR_MASK); // [R1] [R2] [R14]
        end
        if (pop && !empty) begin
            status_nxt[`CMS_BIT_FV] = top[1]; // [R8] [R9]
            status_nxt[`CMS_BIT_LF] = top[0]; // [R11] [R12]
            sp_nxt = sp_r - 5'h01;
        end else if (push && !pop && !full) begin
            sp_nxt = sp_r + 5'h01;
            if (loop_start | endless_loop_start)
                status_nxt[`CMS_BIT_LF] = 1'b1; // [R10]
            if (endless_loop_start)
                status_nxt[`CMS_BIT_FV] = 1'b1; // [R7]
        end
        status_nxt[`CMS_BIT_RSV] = 1'b0;
    end

    always @* begin
        rd_nxt = 32'h00000000;
        case (wb_adr_i)
            `CMS_ADDR_STATUS: rd_nxt = {8'h00, status_r};
            `CMS_ADDR_LOOPCTL: rd_nxt = {29'h00000000, ovf_r, full, empty};
            `CMS_ADDR_STACK: rd_nxt = {27'h0000000, sp_r};
            default: rd_nxt = 32'h00000000;
        endcase
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            status_r <= `CMS_STATUS_RESET; // [R19]
            sp_r <= {`CMS_STACK_PTR_W{1'b0}};
            ovf_r <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            cache_enable <= 1'b0;
            rounding_mode_select <= 1'b0;
            arith_saturation_mode <= 1'b0;
            sixteen_bit_arith_mode <= 1'b0;
            endless_loop_flag <= 1'b0;
            loop_active_flag <= 1'b0;
            double_precision_mode <= 1'b0;
            loop_end_detect <= 1'b0;
            stack_error <= 1'b0;
        end else begin
            status_r <= status_nxt;
            sp_r <= sp_nxt;
            // Overflow sticky; a new error wins over the clear
            if ((push && !pop && full) || (pop && empty))
                ovf_r <= 1'b1;
            else if (clr_wr)
                ovf_r <= 1'b0;
            if (push && !pop && !full)
                stack_mem[sp_r[3:0]] <= {status_r[`CMS_BIT_FV], status_r[`CMS_BIT_LF]}; // [R8] [R11]
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_nxt : 32'h00000000;
            cache_enable <= status_nxt[`CMS_BIT_CE]; // [R1] [R2]
            rounding_mode_select <= status_nxt[`CMS_BIT_RM]; // [R17]
            arith_saturation_mode <= status_nxt[`CMS_BIT_SM]; // [R18]
            sixteen_bit_arith_mode <= status_nxt[`CMS_BIT_SA]; // [R5] [R6]
            endless_loop_flag <= status_nxt[`CMS_BIT_FV];
            loop_active_flag <= status_nxt[`CMS_BIT_LF];
            double_precision_mode <= status_nxt[`CMS_BIT_DM]; // [R13] [R14]
            loop_end_detect <= status_r[`CMS_BIT_LF] & loop_end_hit; // [R10]
            stack_error <= ovf_r;
        end
    end
endmodule // cms_core_mode_status

// *** design/cms_defs.vh ***
`ifndef CMS_DEFS_VH
`define CMS_DEFS_VH
`define CMS_ADDR_STATUS 4'h0
`define CMS_ADDR_LOOPCTL 4'h4
`define CMS_ADDR_STACK 4'h8
`define CMS_BIT_RM 21
`define CMS_BIT_SM 20
`define CMS_BIT_CE 19
`define CMS_BIT_RSV 18
`define CMS_BIT_SA 17
`define CMS_BIT_FV 16
`define CMS_BIT_LF 15
`define CMS_BIT_DM 14
`define CMS_STATUS_RESET 24'h000000
`define CMS_WR_MASK 24'h3a4000
`define CMS_STACK_DEPTH 16
`define CMS_STACK_PTR_W 5
`endif

// *** tb/cms_chk_assertions.sv ***
`timescale 1ns/1ps
module cms_chk (
    input wire clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, loop_end_hit,
    input wire [3:0] wb_adr_i, wb_sel_i,
    input wire [31:0] wb_dat_i, wb_dat_o,
    input wire loop_start, endless_loop_start, loop_end, return_from_interrupt, cache_enable,
    input wire rounding_mode_select, arith_saturation_mode, sixteen_bit_arith_mode,
    input wire endless_loop_flag, loop_active_flag, double_precision_mode, loop_end_detect
);
default clocking @(posedge clock); endclocking
default disable iff (!rst_n);
wire pop = loop_end || return_from_interrupt;
wire rd0 = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
a_ack: assert property (p_ack) else $error("ack missing");
property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
a_pulse: assert property (p_pulse) else $error("ack too long");
property p_rsv; rd0 |-> !wb_dat_o[18]; endproperty
a_rsv: assert property (p_rsv) else $error("bit 18 set");
property p_rd; rd0 |-> wb_dat_o[19] == cache_enable && wb_dat_o[17] == sixteen_bit_arith_mode;
endproperty
a_rd: assert property (p_rd) else $error("mode out differs");
property p_wr; wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[2] && wb_sel_i[1] |=>
    rounding_mode_select == $past(wb_dat_i[21]) && double_precision_mode == $past(wb_dat_i[14]);
endproperty
a_wr: assert property (p_wr) else $error("write lost");
property p_lf; loop_start && !pop |-> ##1 loop_active_flag; endproperty
a_lf: assert property (p_lf) else $error("loop flag");
property p_fv; endless_loop_start && !pop |-> ##1 endless_loop_flag; endproperty
a_fv: assert property (p_fv) else $error("endless flag");
property p_led; loop_end_detect == ($past(loop_active_flag) && $past(loop_end_hit)); endproperty
a_led: assert property (p_led) else $error("end detect");
property p_rst; $rose(rst_n) |-> !(cache_enable || rounding_mode_select ||
    arith_saturation_mode || double_precision_mode || loop_active_flag); endproperty
a_rst: assert property (p_rst) else $error("reset value");
endmodule // cms_chk
bind cms_core_mode_status cms_chk u_chk (.*);

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
logic clock = 0, rst_n = 0, cyc = 0, we = 0, lh = 0;
logic [3:0] adr = 0;
logic [31:0] di = 0, d;
logic [4:0] ev = 0;
wire [31:0] dato;
wire ack, ce, rm, sm, sa, fv, lf, dm, led, serr;
int n_fail = 0, compares = 0, i;
logic [4:0] evs[6] = '{1, 2, 16, 4, 8, 16};
logic [1:0] fl[6] = '{1, 3, 1, 0, 0, 0};
cms_core_mode_status dut (.clock, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(di), .wb_dat_o(dato), .wb_ack_o(ack),
    .loop_start(ev[0]), .endless_loop_start(ev[1]), .loop_end(ev[2]), .int_entry(ev[3]),
    .return_from_interrupt(ev[4]), .loop_end_hit(lh), .burst_enable(1'b0), .cache_enable(ce),
    .rounding_mode_select(rm), .arith_saturation_mode(sm), .sixteen_bit_arith_mode(sa),
    .endless_loop_flag(fv), .loop_active_flag(lf), .double_precision_mode(dm),
    .loop_end_detect(led), .stack_error(serr));
initial forever #25 clock = ~clock;
task stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
task chk(input string s, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
        n_fail++;
        $display("MISMATCH %s exp %h got %h", s, e, g);
    end
endtask
task xfer(input logic w, input logic [3:0] a, input logic [31:0] v);
    int k;
    k = 0;
    cyc <= 1; we <= w; adr <= a; di <= v;
    do begin
        @(posedge clock);
        k++;
    end while (ack !== 1'b1 && k < 20);
    d = dato;
    cyc <= 0;
    if (k >= 20) begin
        n_fail++;
        stop_test;
    end
    @(posedge clock);
endtask
task evp(input logic [4:0] e, input logic [1:0] x);
    ev <= e;
    @(posedge clock);
    ev <= 0;
    repeat (2) @(posedge clock);
    chk("flags", {30'h0, x}, {30'h0, fv, lf});
endtask
initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1;
    xfer(0, 4'h0, 0); chk("status", 0, d);
    // No double-precision algorithm runs here
    xfer(1, 4'h0, 32'hffffffff);
    chk("modes", 32'h7c, {ce, rm, sm, sa, dm, fv, lf});
    xfer(0, 4'h0, 0); chk("status", 32'h3a4000, d);
    xfer(1, 4'hc, 32'hffffffff); xfer(0, 4'hc, 0); chk("unmapped", 0, d);
    xfer(1, 4'h0, 0); xfer(0, 4'h0, 0); chk("cleared", 0, {d[31:2], ce, dm});
    lh <= 1;
    for (i = 0; i < 6; i++) evp(evs[i], fl[i]);
    evp(1, 1); chk("end_detect", 1, {31'h0, led});
    xfer(0, 4'h8, 0); chk("depth", 1, d);
    evp(4, 0); chk("end_detect", 0, {31'h0, led});
    evp(16, 0); chk("stack_error", 1, {31'h0, serr});
    xfer(0, 4'h4, 0); chk("loopctl", 5, d);
    xfer(1, 4'h4, 1); xfer(0, 4'h4, 0); chk("loopctl", 1, d);
    chk("stack_error", 0, {31'h0, serr});
    stop_test;
end
endmodule // tb_top
